// ==== hdl/lirc_pkg.sv ====
package lirc_pkg;
  // Register counts
  localparam int MODULE_CNT = 8;
  localparam int CHANNEL_CNT = 3;
  // Register offsets
  localparam logic [7:0] MODULE0_LEVEL_OFS = 8'h07;
  localparam logic [7:0] MODULE1_LEVEL_OFS = 8'h08;
  localparam logic [7:0] MODULE2_LEVEL_OFS = 8'h09;
  localparam logic [7:0] MODULE3_LEVEL_OFS = 8'h0a;
  localparam logic [7:0] MODULE4_LEVEL_OFS = 8'h0b;
  localparam logic [7:0] MODULE5_LEVEL_OFS = 8'h0c;
  localparam logic [7:0] MODULE6_LEVEL_OFS = 8'h0d;
  localparam logic [7:0] MODULE7_LEVEL_OFS = 8'h0e;
  localparam logic [7:0] CHANNEL0_MIX_OFS = 8'h0f;
  localparam logic [7:0] CHANNEL1_MIX_OFS = 8'h10;
  localparam logic [7:0] CHANNEL2_MIX_OFS = 8'h11;
  // Reset values
  localparam logic [7:0] LEVEL_RST = 8'hff;
  localparam logic [7:0] MIX_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  // Codes of interest
  localparam logic [7:0] FULL_CODE = 8'hff;
  localparam logic [7:0] HALF_CODE = 8'h80;
  localparam logic [7:0] ZERO_CODE = 8'h00;
  // Rounding term of the log curve
  localparam logic [15:0] LOG_ROUND = 16'h00ff;

  // Register access from the serial front end
  typedef struct packed {
    logic wr;           // Write strobe
    logic rd;           // Read strobe
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } lirc_reg_req_s;

  // Values held by the neighbouring configuration and bank registers
  typedef struct packed {
    logic [7:0] select;    // Per-module shared select bits
    logic log_scale;       // 1 = log curve, 0 = linear
    logic [7:0] level;     // Shared intensity
    logic [7:0] mix_a;     // Shared mix for channel 0
    logic [7:0] mix_b;     // Shared mix for channel 1
    logic [7:0] mix_c;     // Shared mix for channel 2
  } lirc_shared_s;
endpackage

// ==== hdl/lirc_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module lirc_regs
  import lirc_pkg::*;
(
  input wire logic sys_clk,                       // Device clock
  input wire logic reset,                         // Async reset, active high
  input wire lirc_reg_req_s reg_req,              // Register access
  input wire lirc_shared_s shared,                // Shared bank settings
  output logic [7:0] reg_rdata,                   // Read data
  output logic reg_rvalid,                        // Read data valid pulse
  output logic [MODULE_CNT-1:0][7:0] module_level, // Effective intensities
  output logic [CHANNEL_CNT-1:0][15:0] channel_duty // Channel duty of module 0
);

  logic [MODULE_CNT-1:0][7:0] level_ff;      // Intensity registers
  logic [CHANNEL_CNT-1:0][7:0] mix_ff;       // Mix registers
  logic [7:0] reg_rdata_ff;                  // Read data register
  logic reg_rvalid_ff;                       // Read valid register
  logic [MODULE_CNT-1:0][7:0] level_eff_ff;  // Effective intensities
  logic [CHANNEL_CNT-1:0][15:0] duty_ff;     // Channel duties
  logic [MODULE_CNT-1:0][7:0] nxt_level_eff; // Mapped intensities
  logic [CHANNEL_CNT-1:0][7:0] nxt_mix_src;  // Selected mix values
  logic [CHANNEL_CNT-1:0][15:0] nxt_duty;    // Mix times intensity
  logic [7:0] nxt_rdata;                     // Decoded read data

  // Whether an address is entry idx of a block of registers
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] base,
                               input int idx);
    logic [7:0] diff;
    diff = addr - base;
    return diff == 8'(idx);
  endfunction

  // Log-style curve: square of the code, end points kept
  function automatic logic [7:0] log_map(input logic [7:0] code);
    logic [15:0] sq;
    sq = 16'({8'h00, code} * {8'h00, code}) + LOG_ROUND;
    return sq[15:8];
  endfunction

  // Product of two byte fractions, 0xfe01 is full scale
  function automatic logic [15:0] scale(input logic [7:0] a, input logic [7:0] b);
    return 16'({8'h00, a} * {8'h00, b});
  endfunction

  // Intensity register writes
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      level_ff <= {MODULE_CNT{LEVEL_RST}};
    end
    else
    begin
      for (int i = 0; i < MODULE_CNT; i++)
      begin
        // One register per module
        if (reg_req.wr && hit(reg_req.addr, MODULE0_LEVEL_OFS, i))
        begin
          level_ff[i] <= reg_req.wdata;
        end
      end
    end
  end

  // A write to the top intensity offset lands in the last register
  level_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.wr && reg_req.addr == MODULE7_LEVEL_OFS |=> level_ff[7] == $past(reg_req.wdata))
    else $error("intensity write not stored");

  // A write to the base intensity offset lands in the first register
  level_base_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.wr && reg_req.addr == MODULE0_LEVEL_OFS |=> level_ff[0] == $past(reg_req.wdata))
    else $error("first intensity write not stored");

  // Without a write the intensity registers keep their values
  level_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !reg_req.wr |=> $stable(level_ff))
    else $error("intensity changed without a write");

  // Mix register writes
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mix_ff <= {CHANNEL_CNT{MIX_RST}};
    end
    else
    begin
      for (int c = 0; c < CHANNEL_CNT; c++)
      begin
        // One register per channel
        if (reg_req.wr && hit(reg_req.addr, CHANNEL0_MIX_OFS, c))
        begin
          mix_ff[c] <= reg_req.wdata;
        end
      end
    end
  end

  // A write to the top mix offset lands in the last register
  mix_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.wr && reg_req.addr == CHANNEL2_MIX_OFS |=> mix_ff[2] == $past(reg_req.wdata))
    else $error("mix write not stored");

  // A write to the base mix offset lands in the first register
  mix_base_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.wr && reg_req.addr == CHANNEL0_MIX_OFS |=> mix_ff[0] == $past(reg_req.wdata))
    else $error("first mix write not stored");

  // Without a write the mix registers keep their values
  mix_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !reg_req.wr |=> $stable(mix_ff))
    else $error("mix changed without a write");

  // Writes outside both blocks leave every register alone
  stray_write_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.wr && (reg_req.addr < MODULE0_LEVEL_OFS || reg_req.addr > CHANNEL2_MIX_OFS)
      |=> $stable(level_ff) && $stable(mix_ff))
    else $error("stray write changed a register");

  // Read decode, unmapped offsets return zero
  always_comb
  begin
    nxt_rdata = RDATA_RST;
    for (int i = 0; i < MODULE_CNT; i++)
    begin
      // Intensity hit
      if (hit(reg_req.addr, MODULE0_LEVEL_OFS, i))
      begin
        nxt_rdata = level_ff[i];
      end
    end
    for (int c = 0; c < CHANNEL_CNT; c++)
    begin
      // Mix hit
      if (hit(reg_req.addr, CHANNEL0_MIX_OFS, c))
      begin
        nxt_rdata = mix_ff[c];
      end
    end
  end

  // Read data register, answers one cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata_ff <= RDATA_RST;
      reg_rvalid_ff <= 1'b0;
    end
    else
    begin
      reg_rvalid_ff <= reg_req.rd;
      // Data holds until the next read
      if (reg_req.rd)
      begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

  // Read of an intensity register returns its held value
  read_back_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.rd && reg_req.addr == MODULE3_LEVEL_OFS && !reg_req.wr
      |=> reg_rvalid && reg_rdata == $past(level_ff[3]))
    else $error("read back mismatch");

  // Every read strobe is answered on the next edge
  read_valid_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.rd |=> reg_rvalid)
    else $error("read not answered");

  // Valid is a single pulse per strobe
  valid_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
    !reg_req.rd |=> !reg_rvalid)
    else $error("valid without a read");

  // Read data holds until the next read
  rdata_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    !reg_req.rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // Offsets above the mix block read as zero
  high_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.rd && reg_req.addr > CHANNEL2_MIX_OFS |=> reg_rdata == RDATA_RST)
    else $error("unmapped high read not zero");

  // Offsets below the intensity block read as zero
  low_read_a: assert property (@(posedge sys_clk) disable iff (reset)
    reg_req.rd && reg_req.addr < MODULE0_LEVEL_OFS |=> reg_rdata == RDATA_RST)
    else $error("unmapped low read not zero");

  // Source selection and intensity mapping
  always_comb
  begin
    for (int i = 0; i < MODULE_CNT; i++)
    begin
      // Shared or own intensity, then curve
      nxt_level_eff[i] = shared.select[i] ? shared.level : level_ff[i];
      if (shared.log_scale)
      begin
        nxt_level_eff[i] = log_map(nxt_level_eff[i]);
      end
    end
    // Channels of module 0 take bank A, B, C when shared
    nxt_mix_src[0] = shared.select[0] ? shared.mix_a : mix_ff[0];
    nxt_mix_src[1] = shared.select[0] ? shared.mix_b : mix_ff[1];
    nxt_mix_src[2] = shared.select[0] ? shared.mix_c : mix_ff[2];
    for (int c = 0; c < CHANNEL_CNT; c++)
    begin
      // Zero in either factor keeps the channel dark
      nxt_duty[c] = scale(nxt_mix_src[c], nxt_level_eff[0]);
    end
  end

  // Effective intensity and duty registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      level_eff_ff <= {MODULE_CNT{LEVEL_RST}};
      duty_ff <= {CHANNEL_CNT{DUTY_RST}};
    end
    else
    begin
      level_eff_ff <= nxt_level_eff;
      duty_ff <= nxt_duty;
    end
  end

  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign module_level = level_eff_ff;
  assign channel_duty = duty_ff;

  // Full code passes the intensity through unchanged
  full_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.log_scale && !shared.select[0] && level_ff[0] == FULL_CODE
      |=> module_level[0] == FULL_CODE && channel_duty[0] == scale($past(mix_ff[0]), FULL_CODE))
    else $error("full intensity wrong");

  // Mid-scale intensity halves a full mix
  half_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.log_scale && !shared.select[0] && level_ff[0] == HALF_CODE && mix_ff[1] == FULL_CODE
      |=> channel_duty[1] == 16'h7f80)
    else $error("half intensity wrong");

  // Zero intensity darkens all three channels
  zero_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.select[0] && level_ff[0] == ZERO_CODE |=> channel_duty == '0)
    else $error("zero intensity not dark");

  // Full mix gives the whole intensity
  full_mix_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.select[0] && mix_ff[0] == FULL_CODE
      |=> channel_duty[0] == scale(FULL_CODE, $past(nxt_level_eff[0])))
    else $error("full mix wrong");

  // Half mix gives half the intensity
  half_mix_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.select[0] && mix_ff[2] == HALF_CODE
      |=> channel_duty[2] == scale(HALF_CODE, $past(nxt_level_eff[0])))
    else $error("half mix wrong");

  // Zero mix keeps its channel off
  zero_mix_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.select[0] && mix_ff[1] == ZERO_CODE |=> channel_duty[1] == DUTY_RST)
    else $error("zero mix not off");

  // Shared select swaps in the shared intensity
  shared_select_a: assert property (@(posedge sys_clk) disable iff (reset)
    shared.select[3] && !shared.log_scale |=> module_level[3] == $past(shared.level))
    else $error("shared intensity not used");

  // Module 0 also follows the shared intensity
  shared_level_a: assert property (@(posedge sys_clk) disable iff (reset)
    shared.select[0] && !shared.log_scale |=> module_level[0] == $past(shared.level))
    else $error("module 0 shared intensity not used");

  // Shared mix and shared intensity form the duty
  shared_duty_a: assert property (@(posedge sys_clk) disable iff (reset)
    shared.select[0] && !shared.log_scale
      |=> channel_duty[1] == {8'h00, $past(shared.mix_b)} * {8'h00, $past(shared.level)})
    else $error("shared duty wrong");

  // Log curve maps mid-scale to a quarter
  log_curve_a: assert property (@(posedge sys_clk) disable iff (reset)
    shared.log_scale && !shared.select[5] && level_ff[5] == HALF_CODE
      |=> module_level[5] == 8'h40)
    else $error("log curve wrong");

  // Log curve keeps the full code
  log_full_a: assert property (@(posedge sys_clk) disable iff (reset)
    shared.log_scale && !shared.select[5] && level_ff[5] == FULL_CODE
      |=> module_level[5] == FULL_CODE)
    else $error("log curve end point wrong");

  // Linear curve passes the register straight through
  linear_pass_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.log_scale && !shared.select[1] |=> module_level[1] == $past(level_ff[1]))
    else $error("linear curve wrong");

  // Duty is the product of the two register fractions
  duty_product_a: assert property (@(posedge sys_clk) disable iff (reset)
    !shared.select[0] && !shared.log_scale
      |=> channel_duty[0] == {8'h00, $past(mix_ff[0])} * {8'h00, $past(level_ff[0])})
    else $error("duty not a product");

endmodule
`default_nettype wire

// ==== verif/lirc_bank_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Neighbouring config and bank registers seen by the block
module lirc_bank_model
  import lirc_pkg::*;
(
  input wire logic sys_clk, // Device clock
  input wire logic reset, // Async reset, active high
  input wire lirc_reg_req_s reg_req, // Same strobe bus as the block
  output lirc_shared_s shared // Held bank settings
);
  // Log curve on after reset, bank level full, mixes off
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      shared <= '{8'h00, 1'b1, 8'hff, 8'h00, 8'h00, 8'h00};
    else if (reg_req.wr)
      case (reg_req.addr)
        8'h01: shared.log_scale <= reg_req.wdata[5];
        8'h02: shared.select <= reg_req.wdata;
        8'h03: shared.level <= reg_req.wdata;
        8'h04: shared.mix_a <= reg_req.wdata;
        8'h05: shared.mix_b <= reg_req.wdata;
        8'h06: shared.mix_c <= reg_req.wdata;
        default: ;
      endcase
  end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import lirc_pkg::*;
;
  logic sys_clk = 1'b0; // Device clock
  logic reset = 1'b1; // Held for two cycles
  lirc_reg_req_s req = '0; // Register strobes
  lirc_shared_s shr; // From the bank model
  logic [7:0] rdata; // Read data
  logic rvalid; // Read data valid
  logic [MODULE_CNT-1:0][7:0] lvl; // Effective intensities
  logic [CHANNEL_CNT-1:0][15:0] duty; // Module 0 channel duty
  int n_fail = 0;
  int checked = 0;

  lirc_regs lirc_regs_i (.sys_clk(sys_clk), .reset(reset), .reg_req(req), .shared(shr),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .module_level(lvl), .channel_duty(duty));
  lirc_bank_model lirc_bank_model_i (.sys_clk(sys_clk), .reset(reset), .reg_req(req),
    .shared(shr));

  initial forever #4 sys_clk = ~sys_clk;

  // Compare and count
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      n_fail++;
    end
  endtask

  // One write, taken at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge sys_clk);
    #1;
    req.wr = 1'b0;
    // Idle edge so the next strobe is not raised in the same step
    @(posedge sys_clk);
    #1;
  endtask

  // One read; answer stands the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    @(posedge sys_clk);
    #1;
    req.rd = 1'b0;
    chk("read valid", 16'h0001, {15'h0, rvalid});
    chk("read data", {8'h0, exp}, {8'h0, rdata});
    // Valid lasts one cycle, data stays until the next read
    @(posedge sys_clk);
    #1;
    chk("read valid end", 16'h0000, {15'h0, rvalid});
    chk("read data held", {8'h0, exp}, {8'h0, rdata});
  endtask

  // Register update then output update
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 11; i++)
      rd(8'(8'h07 + i), (i < 8) ? LEVEL_RST : MIX_RST);
    chk("level after reset", {8'h0, LEVEL_RST}, {8'h0, lvl[7]});
    chk("duty after reset", DUTY_RST, duty[0]);
    $display("test reset done");
  endtask

  task automatic t_rw;
    for (int i = 0; i < 11; i++)
      wr(8'(8'h07 + i), 8'(8'h31 + i * 7));
    for (int i = 0; i < 11; i++)
      rd(8'(8'h07 + i), 8'(8'h31 + i * 7));
    wr(8'h12, 8'h5a);
    rd(8'h12, 8'h00);
    rd(8'h03, 8'h00);
    $display("test readback done");
  endtask

  task automatic t_duty;
    logic [15:0] tab [5] = '{16'hffff, 16'h80ff, 16'h00ff, 16'hff80, 16'hff00};
    wr(8'h01, 8'h00);
    for (int k = 0; k < 5; k++)
    begin
      wr(8'h07, tab[k][15:8]);
      for (int c = 0; c < 3; c++)
        wr(8'(8'h0f + c), tab[k][7:0]);
      settle;
      chk("level", {8'h0, tab[k][15:8]}, {8'h0, lvl[0]});
      for (int c = 0; c < 3; c++)
        chk("duty", 16'(tab[k][15:8]) * 16'(tab[k][7:0]), duty[c]);
    end
    $display("test duty done");
  endtask

  task automatic t_log;
    logic [7:0] code [3] = '{8'hff, 8'h80, 8'h00};
    logic [7:0] want [3] = '{8'hff, 8'h40, 8'h00};
    wr(8'h01, 8'h20);
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h0c, code[k]);
      settle;
      chk("log level", {8'h0, want[k]}, {8'h0, lvl[5]});
    end
    $display("test log done");
  endtask

  task automatic t_bank;
    wr(8'h01, 8'h00);
    wr(8'h03, 8'h80);
    wr(8'h04, 8'hff);
    wr(8'h05, 8'h80);
    wr(8'h06, 8'h00);
    wr(8'h02, 8'h09);
    settle;
    chk("shared level", 16'h0080, {8'h0, lvl[3]});
    chk("own level", 16'h0038, {8'h0, lvl[1]});
    chk("shared duty a", 16'h7f80, duty[0]);
    chk("shared duty b", 16'h4000, duty[1]);
    chk("shared duty c", 16'h0000, duty[2]);
    $display("test bank done");
  endtask

  // Reset in mid-run brings written registers back
  task automatic t_rerun;
    wr(8'h09, 8'h12);
    wr(8'h10, 8'h34);
    reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chk("level after reset", {8'h0, LEVEL_RST}, {8'h0, lvl[2]});
    chk("duty after reset", DUTY_RST, duty[1]);
    rd(8'h09, LEVEL_RST);
    rd(8'h10, MIX_RST);
    $display("test second reset done");
  endtask

  // Counts, verdict, stop
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_reset;
    t_rw;
    t_duty;
    t_log;
    t_bank;
    t_rerun;
    end_sim;
  end
endmodule
`default_nettype wire
